// ==== rtl/pmt_top.sv ====
// period match timer: counter, period, prescale, postscale, bus slave, irq
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

module pmt_top (
  // clock and reset
  input  wire logic                          sys_clk_in,
  input  wire logic                          rst_n_in,
  // avalon-mm slave
  input  wire logic [pmt_pkg::PMT_ADDR_W-1:0] avs_address_in,
  input  wire logic                          avs_read_in,
  input  wire logic                          avs_write_in,
  input  wire logic [31:0]                   avs_writedata_in,
  input  wire logic [3:0]                    avs_byteenable_in,
  output logic      [31:0]                   avs_readdata_out,
  output logic                               avs_waitrequest_out,
  // interrupt
  output logic                               irq_out,
  // serial port shift clock source
  output logic                               ssp_match_out,
  // pwm time base
  output logic      [7:0]                    pwm_count_out,
  output logic      [7:0]                    pwm_period_out,
  output logic                               pwm_match_out
);
  import pmt_pkg::*;

  // ==========================================================================
  // declarations
  // ==========================================================================
  logic        wait_q;
  logic        wait_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  logic        req;
  logic        wr_go;
  logic        sel_flags;
  logic        sel_count;
  logic        sel_control;
  logic        sel_enables;
  logic        sel_period;
  logic        wr_flags;
  logic        wr_count;
  logic        wr_control;
  logic        wr_enables;
  logic        wr_period;
  logic [7:0]  wbyte;

  logic [1:0]  div_q;
  logic [1:0]  div_d;
  logic        instr_tick;

  logic [7:0]  count_q;
  logic [7:0]  count_d;
  logic [6:0]  control_q;
  logic [6:0]  control_d;
  logic [7:0]  period_q;
  logic [7:0]  period_d;
  logic        flag_q;
  logic        flag_d;
  logic        enable_q;
  logic        enable_d;

  logic        match_q;
  logic        match_d;
  logic        irq_q;
  logic        irq_d;

  logic        counter_on;
  logic [1:0]  prescale_select;
  logic [3:0]  postscale_select;
  logic        scaler_clear;
  logic        pre_tick;
  logic        post_done;
  logic        count_step;
  logic        period_hit;

  // ==========================================================================
  // control fields
  // ==========================================================================
  assign counter_on       = control_q[PMT_CTL_ON_BIT];
  assign prescale_select  = control_q[PMT_CTL_PRE_LSB +: 2];
  assign postscale_select = control_q[PMT_CTL_POST_LSB +: 4];

  // ==========================================================================
  // bus decode
  // ==========================================================================
  // one wait state: a request is answered one cycle after it is first seen
  assign req   = avs_read_in || avs_write_in;
  assign wr_go = avs_write_in && !wait_q && avs_byteenable_in[0];
  assign wbyte = avs_writedata_in[7:0];

  always_comb begin
    sel_flags   = 1'b0;
    sel_count   = 1'b0;
    sel_control = 1'b0;
    sel_enables = 1'b0;
    sel_period  = 1'b0;
    if (avs_address_in == PMT_ADDR_IRQ_FLAGS) begin
      sel_flags = 1'b1;
    end else if (avs_address_in == PMT_ADDR_COUNT) begin
      sel_count = 1'b1;
    end else if (avs_address_in == PMT_ADDR_CONTROL) begin
      sel_control = 1'b1;
    end else if (avs_address_in == PMT_ADDR_IRQ_ENABLES) begin
      sel_enables = 1'b1;
    end else if (avs_address_in == PMT_ADDR_PERIOD) begin
      sel_period = 1'b1;
    end
  end

  assign wr_flags   = wr_go && sel_flags;
  assign wr_count   = wr_go && sel_count;
  assign wr_control = wr_go && sel_control;
  assign wr_enables = wr_go && sel_enables;
  assign wr_period  = wr_go && sel_period;

  // ==========================================================================
  // bus handshake and read data
  // ==========================================================================
  always_comb begin
    wait_d  = 1'b1;
    rdata_d = rdata_q;
    if (req && wait_q) begin
      wait_d  = 1'b0;
      // unmapped addresses and unimplemented bits read as zero
      rdata_d = 32'h0000_0000;
      if (sel_flags) begin
        rdata_d[PMT_IRQ_MATCH] = flag_q;
      end else if (sel_count) begin
        rdata_d[7:0] = count_q;
      end else if (sel_control) begin
        rdata_d[6:0] = control_q;
      end else if (sel_enables) begin
        rdata_d[PMT_IRQ_MATCH] = enable_q;
      end else if (sel_period) begin
        rdata_d[7:0] = period_q;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================================
  // instruction clock divider
  // ==========================================================================
  // free running, so the prescaler sees an evenly spaced quarter-rate tick
  always_comb begin
    if (div_q == PMT_DIV_LAST) begin
      div_d = PMT_RST_DIV;
    end else begin
      div_d = div_q + 2'h1;
    end
  end

  assign instr_tick = (div_q == PMT_DIV_LAST) && counter_on;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      div_q <= PMT_RST_DIV;
    end else begin
      div_q <= div_d;
    end
  end

  // ==========================================================================
  // scalers
  // ==========================================================================
  assign scaler_clear = wr_count || wr_control;

  pmt_prescaler u_prescaler (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .tick_in    (instr_tick),
    .select_in  (prescale_select),
    .clear_in   (scaler_clear),
    .tick_out   (pre_tick)
  );

  // a software counter write overrides the increment in the same cycle
  assign count_step = pre_tick && counter_on && !wr_count;
  assign period_hit = count_step && (count_q == period_q);

  pmt_postscaler u_postscaler (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .match_in   (period_hit),
    .select_in  (postscale_select),
    .clear_in   (scaler_clear),
    .done_out   (post_done)
  );

  // ==========================================================================
  // counter, period and control registers
  // ==========================================================================
  always_comb begin
    count_d   = count_q;
    control_d = control_q;
    period_d  = period_q;
    if (wr_count) begin
      count_d = wbyte;
    end else if (count_step) begin
      if (period_hit) begin
        count_d = 8'h00;
      end else begin
        count_d = count_q + 8'h01;
      end
    end
    if (wr_control) begin
      // bit 7 is dropped; the counter itself is not touched here
      control_d = wbyte[6:0];
    end
    if (wr_period) begin
      period_d = wbyte;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      count_q   <= PMT_RST_COUNT;
      control_q <= PMT_RST_CONTROL;
      period_q  <= PMT_RST_PERIOD;
    end else begin
      count_q   <= count_d;
      control_q <= control_d;
      period_q  <= period_d;
    end
  end

  // ==========================================================================
  // interrupt flag, enable and output
  // ==========================================================================
  always_comb begin
    flag_d   = flag_q;
    enable_d = enable_q;
    if (wr_flags) begin
      // writing zero clears, writing one sets from software
      flag_d = wbyte[PMT_IRQ_MATCH];
    end
    if (post_done) begin
      // a hardware set in the cycle of a clearing write wins
      flag_d = 1'b1;
    end
    if (wr_enables) begin
      enable_d = wbyte[PMT_IRQ_MATCH];
    end
    irq_d = flag_d && enable_d;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      flag_q   <= 1'b0;
      enable_q <= 1'b0;
      irq_q    <= 1'b0;
    end else begin
      flag_q   <= flag_d;
      enable_q <= enable_d;
      irq_q    <= irq_d;
    end
  end

  // ==========================================================================
  // match pulse to serial port and pwm unit
  // ==========================================================================
  // registered so it lines up with the counter having returned to zero
  assign match_d = period_hit;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      match_q <= 1'b0;
    end else begin
      match_q <= match_d;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign avs_readdata_out    = rdata_q;
  assign avs_waitrequest_out = wait_q;
  assign irq_out             = irq_q;
  assign ssp_match_out       = match_q;
  assign pwm_count_out       = count_q;
  assign pwm_period_out      = period_q;
  assign pwm_match_out       = match_q;

endmodule : pmt_top
`default_nettype wire

// ==== rtl/pmt_pkg.sv ====
// constants, register map and field layout of the period match timer
package pmt_pkg;

  // ==========================================================================
  // register indices and byte addresses on the 32-bit bus
  // ==========================================================================
  localparam logic [7:0] PMT_IDX_IRQ_FLAGS   = 8'h0c;
  localparam logic [7:0] PMT_IDX_COUNT       = 8'h11;
  localparam logic [7:0] PMT_IDX_CONTROL     = 8'h12;
  localparam logic [7:0] PMT_IDX_IRQ_ENABLES = 8'h8c;
  localparam logic [7:0] PMT_IDX_PERIOD      = 8'h92;

  localparam int unsigned PMT_ADDR_W = 10;

  localparam logic [9:0] PMT_ADDR_IRQ_FLAGS   = {PMT_IDX_IRQ_FLAGS, 2'b00};
  localparam logic [9:0] PMT_ADDR_COUNT       = {PMT_IDX_COUNT, 2'b00};
  localparam logic [9:0] PMT_ADDR_CONTROL     = {PMT_IDX_CONTROL, 2'b00};
  localparam logic [9:0] PMT_ADDR_IRQ_ENABLES = {PMT_IDX_IRQ_ENABLES, 2'b00};
  localparam logic [9:0] PMT_ADDR_PERIOD      = {PMT_IDX_PERIOD, 2'b00};

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int unsigned PMT_CTL_PRE_LSB  = 0;
  localparam int unsigned PMT_CTL_ON_BIT   = 2;
  localparam int unsigned PMT_CTL_POST_LSB = 3;
  localparam int unsigned PMT_IRQ_MATCH    = 1;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [7:0] PMT_RST_COUNT   = 8'h00;
  localparam logic [6:0] PMT_RST_CONTROL = 7'h00;
  localparam logic [7:0] PMT_RST_PERIOD  = 8'hff;
  localparam logic [3:0] PMT_RST_PRE_CNT = 4'h0;
  localparam logic [3:0] PMT_RST_POST    = 4'h0;
  localparam logic [1:0] PMT_RST_DIV     = 2'h0;

  // ==========================================================================
  // clock division and prescale terminal counts
  // ==========================================================================
  localparam int unsigned PMT_SYS_CLK_HZ   = 40_000_000;
  localparam int unsigned PMT_INSTR_DIV    = 4;
  localparam logic [1:0]  PMT_DIV_LAST     = 2'(PMT_INSTR_DIV - 1);
  localparam logic [3:0]  PMT_PRE_LAST_1   = 4'h0;
  localparam logic [3:0]  PMT_PRE_LAST_4   = 4'h3;
  localparam logic [3:0]  PMT_PRE_LAST_16  = 4'hf;

endpackage : pmt_pkg

// ==== rtl/pmt_prescaler.sv ====
// input prescaler of the period match timer: divides ticks by 1, 4 or 16
`timescale 1ns/1ps
`default_nettype none
module pmt_prescaler (
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  // control
  input  wire logic       tick_in,
  input  wire logic [1:0] select_in,
  input  wire logic       clear_in,
  // result
  output logic            tick_out
);
  import pmt_pkg::*;

  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [3:0] last;

  // ==========================================================================
  // division
  // ==========================================================================
  always_comb begin
    if (select_in[1]) begin
      last = PMT_PRE_LAST_16;
    end else if (select_in[0]) begin
      last = PMT_PRE_LAST_4;
    end else begin
      last = PMT_PRE_LAST_1;
    end
    cnt_d    = cnt_q;
    tick_out = 1'b0;
    if (clear_in) begin
      cnt_d = PMT_RST_PRE_CNT;
    end else if (tick_in) begin
      // a ratio change mid count wraps at once instead of running to 15
      if (cnt_q >= last) begin
        cnt_d    = PMT_RST_PRE_CNT;
        tick_out = 1'b1;
      end else begin
        cnt_d = cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      cnt_q <= PMT_RST_PRE_CNT;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : pmt_prescaler
`default_nettype wire

// ==== rtl/pmt_postscaler.sv ====
// match postscaler of the period match timer: 1:1 to 1:16
`timescale 1ns/1ps
`default_nettype none
module pmt_postscaler (
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  // control
  input  wire logic       match_in,
  input  wire logic [3:0] select_in,
  input  wire logic       clear_in,
  // result
  output logic            done_out
);
  import pmt_pkg::*;

  logic [3:0] cnt_q;
  logic [3:0] cnt_d;

  // ==========================================================================
  // match counting
  // ==========================================================================
  always_comb begin
    cnt_d    = cnt_q;
    done_out = 1'b0;
    if (clear_in) begin
      cnt_d = PMT_RST_POST;
    end else if (match_in) begin
      if (cnt_q >= select_in) begin
        cnt_d    = PMT_RST_POST;
        done_out = 1'b1;
      end else begin
        cnt_d = cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      cnt_q <= PMT_RST_POST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : pmt_postscaler
`default_nettype wire

// ==== tb/pmt_top_checker.sv ====
// port-level assertion checker for the period match timer
`timescale 1ns/1ps
`default_nettype none
module pmt_top_checker (
  // clock and reset
  input wire logic                          sys_clk_in,
  input wire logic                          rst_n_in,
  // avalon-mm slave
  input wire logic [pmt_pkg::PMT_ADDR_W-1:0] avs_address_in,
  input wire logic                          avs_read_in,
  input wire logic                          avs_write_in,
  input wire logic [31:0]                   avs_writedata_in,
  input wire logic [3:0]                    avs_byteenable_in,
  input wire logic [31:0]                   avs_readdata_out,
  input wire logic                          avs_waitrequest_out,
  // timer outputs
  input wire logic                          irq_out,
  input wire logic                          ssp_match_out,
  input wire logic [7:0]                    pwm_count_out,
  input wire logic [7:0]                    pwm_period_out,
  input wire logic                          pwm_match_out
);
  import pmt_pkg::*;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  // ==========================================================================
  // recent accepted writes: register updates may lag the answer edge
  // ==========================================================================
  logic [2:0] wr_hist_q;
  logic [2:0] wr_hist_d;
  always_comb begin
    wr_hist_d = {wr_hist_q[1:0], avs_write_in & ~avs_waitrequest_out};
  end
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) wr_hist_q <= 3'h0;
    else wr_hist_q <= wr_hist_d;
  end

  // ==========================================================================
  // assertions
  // ==========================================================================
  sequence s_quiet_step;
    $changed(pwm_count_out) && (wr_hist_q == 3'h0);
  endsequence
  sequence s_wrap;
    s_quiet_step ##0 (pwm_count_out == 8'h00);
  endsequence

  a_wait_one_cycle: assert property (
    $fell(avs_waitrequest_out) |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  a_req_answered: assert property (
    (avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out)
    else $error("request not answered after one wait state");
  a_idle_no_ack: assert property (
    !avs_read_in && !avs_write_in |=> avs_waitrequest_out)
    else $error("answer without a request");
  a_rdata_upper: assert property (
    !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_ctrl_bit7: assert property (
    !avs_waitrequest_out && avs_read_in
      && avs_address_in == PMT_ADDR_CONTROL |-> !avs_readdata_out[7])
    else $error("control bit 7 reads one");
  a_match_spacing: assert property (
    ssp_match_out |=> !ssp_match_out [*3])
    else $error("match pulses closer than one instruction tick");
  a_match_alias: assert property (
    pwm_match_out == ssp_match_out)
    else $error("pwm match differs from serial match");
  a_match_count_zero: assert property (
    ssp_match_out |-> ##[0:1] pwm_count_out == 8'h00)
    else $error("match pulse without count at zero");
  a_count_step: assert property (
    s_quiet_step |-> pwm_count_out == 8'h00
      || pwm_count_out == $past(pwm_count_out) + 8'h01)
    else $error("count moved by other than one");
  a_wrap_period: assert property (
    s_wrap |-> $past(pwm_count_out) == pwm_period_out)
    else $error("count wrapped away from the period value");
  a_period_hold: assert property (
    $changed(pwm_period_out) |-> wr_hist_q != 3'h0)
    else $error("period changed without a write");
endmodule : pmt_top_checker
`default_nettype wire

// ==== tb/tb_pmt_top.sv ====
// self-checking bench for the period match timer
`timescale 1ns/1ps
`default_nettype none
module tb_pmt_top;
  import pmt_pkg::*;
  localparam int LIMIT = 20000;
  logic        sys_clk_in;
  logic        rst_n_in;
  logic [9:0]  avs_address_in;
  logic        avs_read_in;
  logic        avs_write_in;
  logic [31:0] avs_writedata_in;
  logic [3:0]  avs_byteenable_in;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic        irq_out;
  logic        ssp_match_out;
  logic [7:0]  pwm_count_out;
  logic [7:0]  pwm_period_out;
  logic        pwm_match_out;
  int          err_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          n_match = 0;
  int          n_pwm = 0;
  int          d;
  int          t;
  int          m0;
  int          i;
  int          pre [4] = '{1, 4, 16, 16};
  logic [3:0]  post [3] = '{4'h0, 4'h1, 4'hf};
  logic [7:0]  rv;

  pmt_top DUT (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out),
    .ssp_match_out(ssp_match_out), .pwm_count_out(pwm_count_out),
    .pwm_period_out(pwm_period_out), .pwm_match_out(pwm_match_out));

  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  // match pulses are counted here so waits never miss a one-cycle pulse
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (ssp_match_out === 1'b1) n_match <= n_match + 1;
    if (pwm_match_out === 1'b1) n_pwm <= n_pwm + 1;
    if (cyc == LIMIT) begin
      err_count++;
      wrap_up();
    end
  end

  // ==========================================================================
  // tasks
  // ==========================================================================
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk32

  task automatic xfer(input logic wr, input logic [9:0] a,
                      input logic [7:0] wd, input logic [3:0] be);
    avs_address_in    <= a;
    avs_read_in       <= ~wr;
    avs_write_in      <= wr;
    avs_writedata_in  <= {24'h000000, wd};
    avs_byteenable_in <= be;
    do @(posedge sys_clk_in); while (avs_waitrequest_out !== 1'b0);
    rv = avs_readdata_out[7:0];
    avs_read_in  <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask : xfer

  task automatic wr(input logic [9:0] a, input logic [7:0] wd);
    xfer(1'b1, a, wd, 4'hf);
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00, 4'hf);
    chk8(rv, exp);
  endtask : rd

  task automatic nxt();
    int m;
    m = n_match;
    while (n_match == m) @(posedge sys_clk_in);
  endtask : nxt

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    rst_n_in = 1'b0;
    avs_address_in = 10'h000;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h00000000;
    avs_byteenable_in = 4'hf;
    repeat (4) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    @(posedge sys_clk_in);
    rd(PMT_ADDR_IRQ_FLAGS, 8'h00);
    rd(PMT_ADDR_COUNT, 8'h00);
    rd(PMT_ADDR_CONTROL, 8'h00);
    rd(PMT_ADDR_IRQ_ENABLES, 8'h00);
    rd(PMT_ADDR_PERIOD, 8'hff);
    wr(PMT_ADDR_COUNT, 8'h5a);
    rd(PMT_ADDR_COUNT, 8'h5a);
    chk8(pwm_count_out, 8'h5a);
    wr(PMT_ADDR_PERIOD, 8'h3c);
    rd(PMT_ADDR_PERIOD, 8'h3c);
    chk8(pwm_period_out, 8'h3c);
    wr(PMT_ADDR_CONTROL, 8'hf8);
    rd(PMT_ADDR_CONTROL, 8'h78);
    rd(PMT_ADDR_COUNT, 8'h5a);
    xfer(1'b1, PMT_ADDR_COUNT, 8'h11, 4'h0);
    rd(PMT_ADDR_COUNT, 8'h5a);
    wr(10'h100, 8'h55);
    rd(10'h100, 8'h00);
    // timer is off here: nothing may move
    m0 = n_match;
    repeat (40) @(posedge sys_clk_in);
    rd(PMT_ADDR_COUNT, 8'h5a);
    chk32(32'(n_match - m0), 32'h0);
    wr(PMT_ADDR_COUNT, 8'h00);
    wr(PMT_ADDR_PERIOD, 8'h03);
    for (i = 0; i < 4; i++) begin
      wr(PMT_ADDR_CONTROL, 8'h04 | 8'(i));
      nxt();
      t = cyc;
      nxt();
      chk32(32'(cyc - t), 32'(16 * pre[i]));
    end
    wr(PMT_ADDR_CONTROL, 8'h00);
    wr(PMT_ADDR_COUNT, 8'h00);
    wr(PMT_ADDR_PERIOD, 8'h01);
    wr(PMT_ADDR_IRQ_ENABLES, 8'h02);
    for (i = 0; i < 3; i++) begin
      wr(PMT_ADDR_CONTROL, 8'h00);
      wr(PMT_ADDR_COUNT, 8'h00);
      wr(PMT_ADDR_IRQ_FLAGS, 8'h00);
      m0 = n_match;
      wr(PMT_ADDR_CONTROL, {1'b0, post[i], 3'b100});
      while (irq_out !== 1'b1) @(posedge sys_clk_in);
      wr(PMT_ADDR_CONTROL, 8'h00);
      chk32(32'(n_match - m0), 32'(post[i]) + 32'h1);
      repeat (20) @(posedge sys_clk_in);
      chk32({31'h0, irq_out}, 32'h1);
      rd(PMT_ADDR_IRQ_FLAGS, 8'h02);
    end
    wr(PMT_ADDR_IRQ_ENABLES, 8'h00);
    repeat (3) @(posedge sys_clk_in);
    chk32({31'h0, irq_out}, 32'h0);
    wr(PMT_ADDR_IRQ_ENABLES, 8'h02);
    repeat (3) @(posedge sys_clk_in);
    chk32({31'h0, irq_out}, 32'h1);
    wr(PMT_ADDR_IRQ_FLAGS, 8'h00);
    repeat (3) @(posedge sys_clk_in);
    chk32({31'h0, irq_out}, 32'h0);
    // count write mid-prescale must restart the 16-tick prescale
    wr(PMT_ADDR_PERIOD, 8'h00);
    wr(PMT_ADDR_CONTROL, 8'h06);
    nxt();
    repeat (30) @(posedge sys_clk_in);
    wr(PMT_ADDR_COUNT, 8'h00);
    t = cyc;
    nxt();
    d = cyc - t;
    chk32({31'h0, (d >= 56 && d <= 70)}, 32'h1);
    rst_n_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    @(posedge sys_clk_in);
    rd(PMT_ADDR_COUNT, 8'h00);
    rd(PMT_ADDR_PERIOD, 8'hff);
    rd(PMT_ADDR_CONTROL, 8'h00);
    // the pwm time base must have seen every serial-port match pulse
    chk32(32'(n_pwm), 32'(n_match));
    wrap_up();
  end
endmodule : tb_pmt_top

bind pmt_top pmt_top_checker u_chk (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .irq_out(irq_out),
  .ssp_match_out(ssp_match_out), .pwm_count_out(pwm_count_out),
  .pwm_period_out(pwm_period_out), .pwm_match_out(pwm_match_out));
`default_nettype wire
